// *** design/dicl_top.v ***
/*
 * Drive input command logic: synchronises the programmable terminals,
 * decodes preset speed, ramp set, run latching, coast, alarm reset,
 * external trip, frequency source, DC brake and mains handover.
 * Assumes a single 100 MHz clock, terminals asynchronous to it, and a
 * simple register port with read data one cycle after the read strobe.
 */
// The address map and the plain strobed port were left to the implementer.
// Operation
// RQ1: four select bits form binary code picking stored presets 1 to 15.
// RQ2: code zero uses the active ordinary frequency source reference.
// RQ3: ramp select off gives time set 1, on gives set 2.
// RQ4: unassigned ramp select always gives time set 1.
// RQ5: hold active latches first forward or reverse edge, kept after release.
// RQ6: latched run clears as soon as hold goes inactive.
// RQ7: unassigned hold means run only while forward or reverse held.
// RQ8: coast input disables output at once without raising an alarm.
// RQ9: reset on clears alarm output; reset off clears display and hold.
// RQ10: outside party holds reset at least 10 ms, otherwise inactive.
// RQ11: trip input inactive disables output, shows trip code, asserts alarm.
// RQ12: trip stays latched until alarm reset even if input returns.
// RQ13: source select off uses source 1, on uses source 2.
// RQ14: unassigned source select always uses source 1.
// RQ15: DC brake input active keeps braking on, ignoring configured duration.
// RQ16: DC brake input starts braking even while stopped.
// RQ17: mains handover active at run start starts at 50 or 60 Hz.
// RQ18: configuring party never assigns both mains handover frequencies together.
// RQ19: outside sequence raises handover over 0.1 s before run.
// RQ20: outside sequence overlaps handover and run over 0.2 s.
// RQ21: alarm or coast during handover keeps off, then ordinary start frequency.
// RQ22: with power loss restart enabled, outside keeps coast on on mains.
// RQ23: closed terminal means active unless negative logic is configured.
// RQ24: every terminal is synchronised before decoding.
`timescale 1ns/1ps
`include "dicl_map.vh"
`default_nettype none

module dicl_top #(
  parameter FREQ_W = 16
) (
  // clock and reset
  input  wire              CLK,
  input  wire              RESET_N,
  // terminals, high when closed to the common
  input  wire              PRESET_SEL_BIT0,
  input  wire              PRESET_SEL_BIT1,
  input  wire              PRESET_SEL_BIT2,
  input  wire              PRESET_SEL_BIT3,
  input  wire              RAMP_SET_SELECT,
  input  wire              RUN_LATCH_ENABLE,
  input  wire              RUN_FORWARD_CMD,
  input  wire              RUN_REVERSE_CMD,
  input  wire              COAST_STOP_CMD,
  input  wire              ALARM_RESET_CMD,
  input  wire              EXTERNAL_TRIP_INPUT,
  input  wire              FREQ_SOURCE_SELECT,
  input  wire              DC_BRAKE_REQUEST,
  input  wire              MAINS_HANDOVER,
  // register port
  input  wire [7:0]        REG_ADDR,
  input  wire [31:0]       REG_WDATA,
  input  wire              REG_WR,
  input  wire              REG_RD,
  output reg  [31:0]       REG_RDATA,
  // drive commands
  output reg               RUN_FWD,
  output reg               RUN_REV,
  output reg               OUTPUT_ENABLE,
  output reg               RAMP_SET_TWO,
  output reg  [FREQ_W-1:0] FREQ_REF,
  output reg               DC_BRAKE_ON,
  output reg               MAINS_START,
  output reg               ALARM_OUTPUT,
  output reg  [7:0]        ALARM_CODE
);

  localparam NT = `DICL_N_TERM;
  // synchronisers leave reset at each terminal's idle level, so the open
  // fail-safe trip contact is not read as a trip before the pins arrive
  localparam [NT-1:0] SYNC_IDLE = `DICL_POLARITY_RESET;

  reg  [NT-1:0]     sync1;
  reg  [NT-1:0]     sync2;
  reg  [NT-1:0]     act_q;
  reg  [NT-1:0]     polarity;
  reg  [4:0]        cfg;
  reg  [FREQ_W-1:0] src_one;
  reg  [FREQ_W-1:0] src_two;
  reg  [FREQ_W-1:0] preset [1:15];
  reg               run_held_fwd;
  reg               run_held_rev;
  reg               trip_latched;
  reg               alarm_hold;
  reg               handover_blocked;
  reg               running_q;
  reg  [FREQ_W-1:0] next_freq;
  reg  [FREQ_W-1:0] next_freq_ref;
  reg               next_mains_start;
  reg  [31:0]       next_rdata;
  wire [NT-1:0]     pins;
  wire [NT-1:0]     act;
  wire [3:0]        sel_code;
  wire              run_forward_cmd;
  wire              run_reverse_cmd;
  wire              hold;
  wire              coast;
  wire              rst;
  wire              trip;
  wire              mains;
  wire              fwd_rise;
  wire              rev_rise;
  wire              rst_fall;
  wire              alarm_any;
  wire              run_f;
  wire              run_r;
  wire              run_req;
  wire              run_go;
  wire              run_start;
  wire              src_sel;
  wire [FREQ_W-1:0] ordinary;
  wire [FREQ_W-1:0] mains_freq;
  wire [3:0]        pidx;
  wire              preset_hit;
  genvar            g;
  integer           i;

  assign pins = {MAINS_HANDOVER, DC_BRAKE_REQUEST, FREQ_SOURCE_SELECT,
                 EXTERNAL_TRIP_INPUT, ALARM_RESET_CMD, COAST_STOP_CMD,
                 RUN_REVERSE_CMD, RUN_FORWARD_CMD, RUN_LATCH_ENABLE,
                 RAMP_SET_SELECT, PRESET_SEL_BIT3, PRESET_SEL_BIT2,
                 PRESET_SEL_BIT1, PRESET_SEL_BIT0};

  // two flops per terminal, then polarity; only the second flop is decoded
  generate
    for (g = 0; g < NT; g = g + 1) begin : g_term
      always @(posedge CLK) begin
        if (!RESET_N) begin
          sync1[g] <= SYNC_IDLE[g];
          sync2[g] <= SYNC_IDLE[g];
        end else begin
          sync1[g] <= pins[g];  // RQ24
          sync2[g] <= sync1[g];
        end
      end
      assign act[g] = sync2[g] ^ polarity[g];  // RQ23
    end
  endgenerate

  assign sel_code  = act[`DICL_T_SEL3:`DICL_T_SEL0];
  assign run_forward_cmd       = act[`DICL_T_FWD];
  assign run_reverse_cmd       = act[`DICL_T_REV];
  assign hold      = act[`DICL_T_HOLD] & cfg[`DICL_CFG_HOLD_ASSIGNED];
  assign coast     = act[`DICL_T_COAST];
  assign rst       = act[`DICL_T_RST];
  assign trip      = act[`DICL_T_TRIP];
  assign mains     = act[`DICL_T_MAINS] &
                     (cfg[`DICL_CFG_MAINS50] | cfg[`DICL_CFG_MAINS60]);
  assign fwd_rise  = run_forward_cmd & ~act_q[`DICL_T_FWD];
  assign rev_rise  = run_reverse_cmd & ~act_q[`DICL_T_REV];
  assign rst_fall  = ~rst & act_q[`DICL_T_RST];
  assign alarm_any = trip_latched | alarm_hold;

  // run request: latched in three-wire mode, level in two-wire mode
  assign run_f     = hold ? run_held_fwd : run_forward_cmd;  // RQ7
  assign run_r     = hold ? run_held_rev : run_reverse_cmd;  // RQ7
  assign run_req   = run_f | run_r;
  assign run_go    = run_req & ~coast & ~alarm_any;
  assign run_start = run_go & ~running_q;

  always @(posedge CLK) begin
    if (!RESET_N) begin
      act_q        <= {NT{1'b0}};
      run_held_fwd <= 1'b0;
      run_held_rev <= 1'b0;
      running_q    <= 1'b0;
    end else begin
      act_q     <= act;
      running_q <= run_go;
      if (!hold) begin
        run_held_fwd <= 1'b0;  // RQ6
        run_held_rev <= 1'b0;  // RQ6
      end else if (!run_held_fwd && !run_held_rev) begin
        // only the first edge is kept; the other direction is ignored
        run_held_fwd <= fwd_rise;  // RQ5
        run_held_rev <= rev_rise & ~fwd_rise;  // RQ5
      end
    end
  end

  // trip latch and alarm hold; a new trip wins over a reset in the same cycle
  always @(posedge CLK) begin
    if (!RESET_N) begin
      trip_latched <= 1'b0;
      alarm_hold   <= 1'b0;
      ALARM_OUTPUT <= 1'b0;
      ALARM_CODE   <= `DICL_ALARM_NONE;
    end else begin
      if (trip) begin
        trip_latched <= 1'b1;  // RQ11
        alarm_hold   <= 1'b1;  // RQ12
        ALARM_OUTPUT <= 1'b1;  // RQ11
        ALARM_CODE   <= `DICL_ALARM_EXT_TRIP;  // RQ11
      end else begin
        if (rst) begin
          ALARM_OUTPUT <= 1'b0;  // RQ9
          trip_latched <= 1'b0;  // RQ12
        end
        if (rst_fall) begin
          alarm_hold <= 1'b0;  // RQ9
          ALARM_CODE <= `DICL_ALARM_NONE;  // RQ9
        end
      end
    end
  end

  // handover start: blocked if an alarm or coast is seen while handing over
  always @(posedge CLK) begin
    if (!RESET_N) begin
      handover_blocked <= 1'b0;
    end else if (!mains) begin
      handover_blocked <= 1'b0;
    end else if (coast || alarm_any) begin
      handover_blocked <= 1'b1;  // RQ21
    end
  end

  // source choice before the preset override
  assign src_sel    = act[`DICL_T_SRC] & cfg[`DICL_CFG_SRC_ASSIGNED];  // RQ14
  assign ordinary   = src_sel ? src_two : src_one;  // RQ13
  // sixty wins if both are set; assigning both is the user's error
  assign mains_freq = cfg[`DICL_CFG_MAINS60] ? `DICL_FREQ_60HZ : `DICL_FREQ_50HZ;

  always @* begin
    if (sel_code == 4'h0)
      next_freq = ordinary;  // RQ2
    else
      next_freq = preset[sel_code];  // RQ1
  end

  // a handover start pins the reference at mains frequency until the run ends
  always @* begin
    next_mains_start = MAINS_START;
    next_freq_ref    = FREQ_REF;
    if (run_start) begin
      next_mains_start = mains & ~handover_blocked;  // RQ17 RQ21
    end else if (!run_go) begin
      next_mains_start = 1'b0;
    end
    if (run_start && mains && !handover_blocked) begin
      next_freq_ref = mains_freq;  // RQ17
    end else if (!(MAINS_START && run_go)) begin
      next_freq_ref = next_freq;
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      RUN_FWD       <= 1'b0;
      RUN_REV       <= 1'b0;
      OUTPUT_ENABLE <= 1'b0;
      RAMP_SET_TWO  <= 1'b0;
      FREQ_REF      <= {FREQ_W{1'b0}};
      DC_BRAKE_ON   <= 1'b0;
      MAINS_START   <= 1'b0;
    end else begin
      RUN_FWD <= run_go & run_f;
      RUN_REV <= run_go & run_r & ~run_f;
      // coast and trip cut the output with no ramp
      OUTPUT_ENABLE <= ~coast & ~trip & ~alarm_any;  // RQ8
      RAMP_SET_TWO  <= act[`DICL_T_RAMP] & cfg[`DICL_CFG_RAMP_ASSIGNED];  // RQ3 RQ4
      // level drive, no duration timer, works while stopped
      DC_BRAKE_ON <= act[`DICL_T_DCB];  // RQ15 RQ16
      MAINS_START   <= next_mains_start;
      FREQ_REF      <= next_freq_ref;
    end
  end

  // register port; preset index zero is left unmapped
  assign pidx       = REG_ADDR[5:2];
  assign preset_hit = (REG_ADDR[7:6] == 2'b01) && (REG_ADDR[1:0] == 2'b00) &&
                      (pidx != 4'h0);

  always @(posedge CLK) begin
    if (!RESET_N) begin
      cfg      <= `DICL_CFG_RESET;
      polarity <= `DICL_POLARITY_RESET;
      src_one  <= {FREQ_W{1'b0}};
      src_two  <= {FREQ_W{1'b0}};
      for (i = 1; i <= 15; i = i + 1)
        preset[i] <= {FREQ_W{1'b0}};
    end else if (REG_WR) begin
      case (REG_ADDR)
        `DICL_REG_CFG:      cfg      <= REG_WDATA[4:0];
        `DICL_REG_POLARITY: polarity <= REG_WDATA[NT-1:0];
        `DICL_REG_SRC_ONE:  src_one  <= REG_WDATA[FREQ_W-1:0];
        `DICL_REG_SRC_TWO:  src_two  <= REG_WDATA[FREQ_W-1:0];
        default: begin
          if (preset_hit)
            preset[pidx] <= REG_WDATA[FREQ_W-1:0];
        end
      endcase
    end
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always @* begin
    next_rdata = 32'h0000_0000;
    if (REG_RD) begin
      case (REG_ADDR)
        `DICL_REG_CFG:        next_rdata = {27'h000_0000, cfg};
        `DICL_REG_POLARITY:   next_rdata = {18'h0_0000, polarity};
        `DICL_REG_SRC_ONE:    next_rdata = {{(32-FREQ_W){1'b0}}, src_one};
        `DICL_REG_SRC_TWO:    next_rdata = {{(32-FREQ_W){1'b0}}, src_two};
        `DICL_REG_STATUS:     next_rdata = {12'h000, trip_latched, alarm_hold,
                                            handover_blocked, run_held_fwd,
                                            run_held_rev, running_q, act};
        `DICL_REG_ALARM_CODE: next_rdata = {24'h00_0000, ALARM_CODE};
        default: begin
          if (preset_hit)
            next_rdata = {{(32-FREQ_W){1'b0}}, preset[pidx]};
        end
      endcase
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

endmodule // dicl_top

`default_nettype wire

// *** inc/dicl_map.vh ***
/*
 * Constants for the drive input command logic: register offsets, field
 * positions, reset values, alarm codes and mains frequencies.
 * Assumes a 100 MHz drive clock and an 8-bit register address space.
 */
`ifndef DICL_MAP_VH
`define DICL_MAP_VH

// register offsets (byte addresses, one word each)
`define DICL_REG_CFG        8'h00
`define DICL_REG_POLARITY   8'h04
`define DICL_REG_SRC_ONE    8'h08
`define DICL_REG_SRC_TWO    8'h0C
`define DICL_REG_STATUS     8'h10
`define DICL_REG_ALARM_CODE 8'h14
`define DICL_REG_PRESET_0   8'h40

// configuration register fields
`define DICL_CFG_RAMP_ASSIGNED  0
`define DICL_CFG_HOLD_ASSIGNED  1
`define DICL_CFG_SRC_ASSIGNED   2
`define DICL_CFG_MAINS50        3
`define DICL_CFG_MAINS60        4
`define DICL_CFG_RESET          5'h00

// terminal bit positions in the polarity mask and status
`define DICL_T_SEL0    0
`define DICL_T_SEL1    1
`define DICL_T_SEL2    2
`define DICL_T_SEL3    3
`define DICL_T_RAMP    4
`define DICL_T_HOLD    5
`define DICL_T_FWD     6
`define DICL_T_REV     7
`define DICL_T_COAST   8
`define DICL_T_RST     9
`define DICL_T_TRIP    10
`define DICL_T_SRC     11
`define DICL_T_DCB     12
`define DICL_T_MAINS   13
`define DICL_N_TERM    14
// external trip is active when the terminal is open
`define DICL_POLARITY_RESET 14'h0400

// alarm codes: none, and the code shown for the external trip
`define DICL_ALARM_NONE     8'h00
`define DICL_ALARM_EXT_TRIP 8'h02

// mains frequencies in 0.01 Hz units
`define DICL_FREQ_50HZ 16'h1388
`define DICL_FREQ_60HZ 16'h1770

`endif

// *** sim/dicl_asserts.sv ***
/* Checker for the drive input command logic: terminal to output timing.
   Assumes polarity at reset value and three edges from pin to output. */
`timescale 1ns/1ps
`default_nettype none
module dicl_asserts (
  // clock and reset
  input wire logic       CLK,
  input wire logic       RESET_N,
  // terminals
  input wire logic       RAMP_SET_SELECT,
  input wire logic       RUN_LATCH_ENABLE,
  input wire logic       RUN_FORWARD_CMD,
  input wire logic       COAST_STOP_CMD,
  input wire logic       ALARM_RESET_CMD,
  input wire logic       EXTERNAL_TRIP_INPUT,
  input wire logic       DC_BRAKE_REQUEST,
  // drive commands
  input wire logic       RUN_FWD,
  input wire logic       OUTPUT_ENABLE,
  input wire logic       RAMP_SET_TWO,
  input wire logic       DC_BRAKE_ON,
  input wire logic       MAINS_START,
  input wire logic       ALARM_OUTPUT,
  input wire logic [7:0] ALARM_CODE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  chk_coast_off: assert property (COAST_STOP_CMD [*4] |-> !OUTPUT_ENABLE)
    else $error("output enabled while coasting");
  chk_alarm_cause: assert property ($rose(ALARM_OUTPUT) |-> !$past(EXTERNAL_TRIP_INPUT, 3))
    else $error("alarm raised without a trip");
  chk_trip_shut: assert property (!EXTERNAL_TRIP_INPUT [*4] |->
    ALARM_OUTPUT && ALARM_CODE == 8'h02 && !OUTPUT_ENABLE)
    else $error("open trip terminal not shutting down");
  chk_alarm_clear: assert property ($fell(ALARM_OUTPUT) |-> $past(ALARM_RESET_CMD, 3))
    else $error("alarm output cleared without reset");
  chk_trip_held: assert property ($fell(ALARM_CODE == 8'h02) |->
    $past(ALARM_RESET_CMD, 4) && !$past(ALARM_RESET_CMD, 3))
    else $error("trip code cleared without reset release");
  chk_run_idle: assert property ((!RUN_LATCH_ENABLE && !RUN_FORWARD_CMD) [*4] |-> !RUN_FWD)
    else $error("forward run without command or latch");
  chk_brake_on: assert property (DC_BRAKE_REQUEST [*4] |-> DC_BRAKE_ON)
    else $error("brake off while requested");
  chk_ramp_one: assert property (!RAMP_SET_SELECT [*4] |-> !RAMP_SET_TWO)
    else $error("ramp set two without select");
  cover property (MAINS_START && RUN_FWD);
  cover property (ALARM_OUTPUT ##1 !ALARM_OUTPUT);
  cover property ($rose(DC_BRAKE_ON));
endmodule // dicl_asserts
`default_nettype wire

// *** sim/dicl_partner.sv ***
/* Model of the outside switch and relay sequence on the terminals.
   Assumes the bench sets wanted levels; pins move only at clock edges. */
`timescale 1ns/1ps
`default_nettype none
module dicl_partner #(
  parameter int RST_MIN = 8
) (
  // clock
  input  wire logic        clk,
  // wanted and driven levels
  input  wire logic [13:0] want,
  output var  logic [13:0] pins
);
  int hold_cnt;
  // trip contact closed from power up, so no trip latches
  initial pins = 14'h0400;
  initial hold_cnt = 0;
  always @(posedge clk) begin
    // reset contact kept closed a minimum time, scaled down
    pins     <= {want[13:10], want[9] | (pins[9] && hold_cnt < RST_MIN), want[8:0]};
    hold_cnt <= pins[9] ? hold_cnt + 1 : 0;
  end
endmodule // dicl_partner
`default_nettype wire

// *** sim/testbench.sv ***
/* Self-checking bench for the drive input command logic.
   Assumes the terminal model and checker are compiled before it. */
`timescale 1ns/1ps
`include "dicl_map.vh"
`default_nettype none
module testbench;
  logic        clk = 0;
  logic        reset_n = 0;
  logic [7:0]  addr = 0;
  logic [31:0] wdata = 0;
  logic        wr_s = 0;
  logic        rd_s = 0;
  logic [13:0] want = 14'h0400;
  logic [13:0] pins;
  logic [31:0] rdata;
  logic [15:0] freq;
  logic [7:0]  code;
  logic        run_f, run_r, oe, ramp2, brk, mst, alarm;
  int          bad_count = 0;
  int          samples_checked = 0;
  localparam int HO_LEAD = 20;
  dicl_partner term_u (.clk(clk), .want(want), .pins(pins));
  dicl_top dut_u (
    .CLK(clk), .RESET_N(reset_n),
    .PRESET_SEL_BIT0(pins[0]), .PRESET_SEL_BIT1(pins[1]),
    .PRESET_SEL_BIT2(pins[2]), .PRESET_SEL_BIT3(pins[3]),
    .RAMP_SET_SELECT(pins[4]), .RUN_LATCH_ENABLE(pins[5]),
    .RUN_FORWARD_CMD(pins[6]), .RUN_REVERSE_CMD(pins[7]),
    .COAST_STOP_CMD(pins[8]), .ALARM_RESET_CMD(pins[9]),
    .EXTERNAL_TRIP_INPUT(pins[10]), .FREQ_SOURCE_SELECT(pins[11]),
    .DC_BRAKE_REQUEST(pins[12]), .MAINS_HANDOVER(pins[13]),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
    .REG_RDATA(rdata), .RUN_FWD(run_f), .RUN_REV(run_r), .OUTPUT_ENABLE(oe),
    .RAMP_SET_TWO(ramp2), .FREQ_REF(freq), .DC_BRAKE_ON(brk),
    .MAINS_START(mst), .ALARM_OUTPUT(alarm), .ALARM_CODE(code));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    check("register", exp, rdata);
  endtask
  // two sync stages, output flop and the model edge, plus margin
  task automatic set(input logic [13:0] w);
    @(posedge clk);
    want <= w;
    repeat (10) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pin(input int i, input logic v);
    logic [13:0] w;
    w = want;
    w[i] = v;
    set(w);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100us;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(`DICL_REG_CFG, `DICL_CFG_RESET);
    rd(`DICL_REG_POLARITY, 32'h0000_0400);
    rd(`DICL_REG_PRESET_0, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    wr(`DICL_REG_SRC_ONE, 32'h0000_0100);
    wr(`DICL_REG_SRC_TWO, 32'h0000_0200);
    for (int n = 1; n < 16; n++) wr(`DICL_REG_PRESET_0 + 8'(4 * n), 32'h0000_1000 + n);
    rd(`DICL_REG_PRESET_0 + 8'h3C, 32'h0000_100F);
    rd(`DICL_REG_SRC_TWO, 32'h0000_0200);
    for (int c = 0; c < 17; c++) begin
      set({want[13:4], c[3:0]});
      check("freq", (c % 16) ? 32'h0000_1000 + c : 32'h0000_0100, {16'h0, freq});
    end
    pin(`DICL_T_SRC, 1);
    check("freq", 32'h0000_0100, {16'h0, freq});
    wr(`DICL_REG_CFG, 32'h0000_0004);
    set(want);
    check("freq", 32'h0000_0200, {16'h0, freq});
    pin(`DICL_T_SRC, 0);
    check("freq", 32'h0000_0100, {16'h0, freq});
    wr(`DICL_REG_POLARITY, 32'h0000_0C00);
    rd(`DICL_REG_POLARITY, 32'h0000_0C00);
    set(want);
    check("freq", 32'h0000_0200, {16'h0, freq});
    wr(`DICL_REG_POLARITY, 32'h0000_0400);
    set(want);
    check("freq", 32'h0000_0100, {16'h0, freq});
    pin(`DICL_T_RAMP, 1);
    check("ramp", 0, ramp2);
    wr(`DICL_REG_CFG, 32'h0000_0005);
    set(want);
    check("ramp", 1, ramp2);
    pin(`DICL_T_RAMP, 0);
    check("ramp", 0, ramp2);
    pin(`DICL_T_FWD, 1);
    check("fwd", 1, run_f);
    check("enable", 1, oe);
    pin(`DICL_T_COAST, 1);
    check("enable", 0, oe);
    check("alarm", 0, alarm);
    pin(`DICL_T_COAST, 0);
    pin(`DICL_T_FWD, 0);
    check("fwd", 0, run_f);
    wr(`DICL_REG_CFG, 32'h0000_0007);
    pin(`DICL_T_HOLD, 1);
    pin(`DICL_T_REV, 1);
    pin(`DICL_T_REV, 0);
    check("reverse", 1, run_r);
    pin(`DICL_T_FWD, 1);
    pin(`DICL_T_FWD, 0);
    check("fwd", 0, run_f);
    pin(`DICL_T_HOLD, 0);
    check("reverse", 0, run_r);
    pin(`DICL_T_DCB, 1);
    repeat (100) @(posedge clk);
    @(negedge clk);
    check("brake", 1, brk);
    pin(`DICL_T_DCB, 0);
    check("brake", 0, brk);
    pin(`DICL_T_TRIP, 0);
    pin(`DICL_T_TRIP, 1);
    check("alarm", 1, alarm);
    check("enable", 0, oe);
    check("code", `DICL_ALARM_EXT_TRIP, code);
    rd(`DICL_REG_ALARM_CODE, 32'h0000_0002);
    rd(`DICL_REG_STATUS, 32'h000C_0000);
    pin(`DICL_T_RST, 1);
    check("alarm", 0, alarm);
    check("code", `DICL_ALARM_EXT_TRIP, code);
    pin(`DICL_T_RST, 0);
    set(want);
    check("code", `DICL_ALARM_NONE, code);
    check("enable", 1, oe);
    for (int m = 0; m < 2; m++) begin
      wr(`DICL_REG_CFG, m ? 32'h0000_0010 : 32'h0000_0008);
      pin(`DICL_T_MAINS, 1);
      repeat (HO_LEAD) @(posedge clk);
      pin(`DICL_T_FWD, 1);
      check("mains", 1, mst);
      check("freq", m ? `DICL_FREQ_60HZ : `DICL_FREQ_50HZ, {16'h0, freq});
      repeat (2 * HO_LEAD) @(posedge clk);
      pin(`DICL_T_FWD, 0);
      pin(`DICL_T_MAINS, 0);
    end
    pin(`DICL_T_COAST, 1);
    pin(`DICL_T_MAINS, 1);
    repeat (HO_LEAD) @(posedge clk);
    pin(`DICL_T_FWD, 1);
    check("mains", 0, mst);
    pin(`DICL_T_COAST, 0);
    check("mains", 0, mst);
    check("freq", 32'h0000_0100, {16'h0, freq});
    summarize();
  end
endmodule // testbench
bind dicl_top dicl_asserts chk_u (.CLK, .RESET_N, .RAMP_SET_SELECT, .RUN_LATCH_ENABLE,
  .RUN_FORWARD_CMD, .COAST_STOP_CMD, .ALARM_RESET_CMD, .EXTERNAL_TRIP_INPUT,
  .DC_BRAKE_REQUEST, .RUN_FWD, .OUTPUT_ENABLE, .RAMP_SET_TWO, .DC_BRAKE_ON,
  .MAINS_START, .ALARM_OUTPUT, .ALARM_CODE);
`default_nettype wire
